// [core/flash_loader_pkg.sv]
/*
  constants, states and timing shared by the jtag to serial memory bridge.
  assumes a 100 mhz system clock and a jtag test clock of its own.
*/
package flash_loader_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int BYTE_W = 8; // one serial memory byte
  localparam int CMD_W = 9; // byte plus end-of-command flag
  localparam int CMD_LAST_BIT = 8; // flag position in a command word
  localparam int BUSY_BIT = 8; // busy position in a captured word
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_SYS_NS = 10; // system clock period
  localparam int SCK_HALF_NS = 50; // serial clock half period, least
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
  localparam logic [3:0] SCK_DIV_LAST = 4'(SCK_HALF_CYC - 1);
  localparam logic [3:0] BIT_LAST = 4'(BYTE_W - 1);
  localparam logic [3:0] SYNC_LAST = 4'h2; // returned data crosses two sync flops
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic RST_SELECT_N = 1'b1; // memory deselected
  localparam logic RST_SCK = 1'b0; // serial clock idles low
  localparam logic RST_CHAIN_N = 1'b1; // next device held off
  localparam logic RST_OE = 1'b0; // pins released
  localparam logic RST_USER_MODE = 1'b1; // bridge in user mode once loaded
  // ----------------------------------------
  // serial transfer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    XFER_IDLE = 2'b00,
    XFER_LOW = 2'b01,
    XFER_HIGH = 2'b10,
    XFER_DONE = 2'b11
  } xfer_e;
endpackage

// [core/flash_loader_bridge.sv]
/*
  bridge from a jtag data register to the four serial memory pins.
  assumes a tap controller outside supplies capture, shift and update
  strobes on the test clock, and that pin tristate is resolved outside.
*/
// Operation
// RQ1: jtag configuration aborts active serial configuration
// RQ2: jtag register wired internally to memory pins
// RQ3: host loads byte, bridge forwards to memory
// RQ4: four pins: clock, data in, out, select
// RQ5: only four jtag pins needed by host
// RQ6: host configures only the master device
// RQ7: host straps scheme select to active serial
// RQ8: user mode regardless of completion line
// RQ9: no reconfiguration started on its own
// RQ10: host pulses configuration reset by instruction
// RQ11: reconfiguration resets bridge, user design reloads
// RQ12: pins released so memory configures chain
// RQ13: serial clock optionally from user clock
// RQ14: select doubles flash enable, data out bit1
// RQ15: host holds chain enable input low
// RQ16: chain enable output low once configured
// RQ17: idle keeps select high, clock low
`timescale 1ns/10ps
module flash_loader_bridge (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // jtag side, tap strobes on the test clock
  input wire logic tck,
  input wire logic tdi,
  input wire logic capture_dr,
  input wire logic shift_dr,
  input wire logic update_dr,
  output logic tdo,
  // configuration control
  input wire logic jtag_config_active,
  input wire logic config_reset_pulse,
  input wire logic use_user_clock,
  input wire logic user_clock_in,
  output logic as_abort,
  output logic user_mode,
  output logic reconfig_start,
  output logic chain_enable_out_n,
  // serial memory pins
  output logic serial_memory_clock,
  output logic memory_select_out_n,
  output logic serial_memory_data_out,
  output logic serial_memory_oe,
  input wire logic memory_data_return
);
  // ----------------------------------------
  // state of the test clock domain
  // ----------------------------------------
  typedef struct packed {
    logic [flash_loader_pkg::CMD_W-1:0] shreg; // data register
    logic [flash_loader_pkg::CMD_W-1:0] cmd; // held command word
    logic req_tgl; // new command event
    logic [1:0] done_s; // done toggle synchroniser
    logic tdo; // serial output
  } tck_s;

  // ----------------------------------------
  // state of the system clock domain
  // ----------------------------------------
  typedef struct packed {
    flash_loader_pkg::xfer_e st; // transfer state
    logic [3:0] bit_cnt; // bits sent
    logic [3:0] div; // half period count
    logic [flash_loader_pkg::BYTE_W-1:0] tx; // outgoing byte
    logic [flash_loader_pkg::BYTE_W-1:0] rx; // returned byte
    logic last; // deselect after this byte
    logic [2:0] req_s; // request sync plus previous
    logic done_tgl; // transfer finished event
    logic [1:0] din_s; // memory data sync
    logic [1:0] ucl_s; // user clock sync
    logic ucl_prev; // user clock edge detect
    logic [1:0] jcfg_s; // jtag config sync
    logic [1:0] rcf_s; // config reset sync
    logic rcf_prev; // config reset edge detect
    logic sck; // serial clock pin
    logic sel_n; // select pin
    logic dout; // data pin
    logic oe; // pin drive enable
    logic abort; // active serial abort
    logic reconfig; // reconfiguration begun
    logic chain_n; // chain enable output
    logic umode; // user mode output
  } sys_s;

  tck_s t_reg; // test clock state
  tck_s t_next; // its next value
  sys_s s_reg; // system clock state
  sys_s s_next; // its next value
  logic busy; // command still owned by the system side
  logic tick; // serial clock half period elapsed
  logic req_edge; // new command seen on the system side

  // command in flight until its done toggle returns
  assign busy = t_reg.req_tgl != t_reg.done_s[1];

  // ----------------------------------------
  // test clock domain
  // ----------------------------------------
  // shift, capture and update of the bridge data register
  always_comb begin
    t_next = t_reg;
    t_next.done_s = {t_reg.done_s[0], s_reg.done_tgl};
    if (capture_dr) begin
      // status and last returned byte, rx stable while not busy
      t_next.shreg = {busy, s_reg.rx}; // RQ2
    end else if (shift_dr) begin
      t_next.shreg = {tdi, t_reg.shreg[flash_loader_pkg::CMD_W-1:1]}; // RQ5
    end
    if (update_dr && !busy) begin
      // word held stable for the system side until done returns
      t_next.cmd = t_reg.shreg; // RQ3
      t_next.req_tgl = ~t_reg.req_tgl; // RQ3
    end
    t_next.tdo = t_next.shreg[0];
  end

  // test clock registers
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

  // ----------------------------------------
  // system clock domain
  // ----------------------------------------
  // half period from divider or from user clock rising edge
  assign tick = use_user_clock ? (s_reg.ucl_s[1] & ~s_reg.ucl_prev) // RQ13
              : (s_reg.div == flash_loader_pkg::SCK_DIV_LAST);
  assign req_edge = s_reg.req_s[2] != s_reg.req_s[1];

  // serial engine and configuration control
  always_comb begin
    s_next = s_reg;
    s_next.req_s = {s_reg.req_s[1], s_reg.req_s[0], t_reg.req_tgl};
    s_next.din_s = {s_reg.din_s[0], memory_data_return};
    s_next.ucl_s = {s_reg.ucl_s[0], user_clock_in};
    s_next.ucl_prev = s_reg.ucl_s[1];
    s_next.jcfg_s = {s_reg.jcfg_s[0], jtag_config_active};
    s_next.rcf_s = {s_reg.rcf_s[0], config_reset_pulse};
    s_next.rcf_prev = s_reg.rcf_s[1];
    s_next.abort = s_reg.jcfg_s[1]; // RQ1
    s_next.div = (tick || s_reg.st == flash_loader_pkg::XFER_IDLE) ? 4'h0
               : s_reg.div + 4'h1;
    case (s_reg.st)
      flash_loader_pkg::XFER_IDLE: begin
        // clock parked low while waiting
        s_next.sck = 1'b0; // RQ17
        if (req_edge && !s_reg.reconfig) begin
          s_next.tx = t_reg.cmd[flash_loader_pkg::BYTE_W-1:0]; // RQ3
          s_next.last = t_reg.cmd[flash_loader_pkg::CMD_LAST_BIT];
          s_next.bit_cnt = 4'h0;
          s_next.sel_n = 1'b0; // RQ4
          s_next.st = flash_loader_pkg::XFER_LOW;
        end
      end
      flash_loader_pkg::XFER_LOW: begin
        // data set up while clock low, sampled at rising edge
        // a fast user clock edge is skipped until returned data has synced
        if (tick && s_reg.div >= flash_loader_pkg::SYNC_LAST) begin
          s_next.sck = 1'b1;
          s_next.rx = {s_reg.rx[flash_loader_pkg::BYTE_W-2:0], s_reg.din_s[1]};
          s_next.st = flash_loader_pkg::XFER_HIGH;
        end
      end
      flash_loader_pkg::XFER_HIGH: begin
        // falling edge moves to next bit, msb first
        if (tick) begin
          s_next.sck = 1'b0;
          s_next.tx = {s_reg.tx[flash_loader_pkg::BYTE_W-2:0], 1'b0};
          s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          s_next.st = (s_reg.bit_cnt == flash_loader_pkg::BIT_LAST)
                    ? flash_loader_pkg::XFER_DONE : flash_loader_pkg::XFER_LOW;
        end
      end
      flash_loader_pkg::XFER_DONE: begin
        // end of byte, select held for multi-byte commands
        s_next.sel_n = s_reg.last; // RQ17
        s_next.done_tgl = ~s_reg.done_tgl;
        s_next.st = flash_loader_pkg::XFER_IDLE;
      end
      default: begin
        s_next.st = flash_loader_pkg::XFER_IDLE;
      end
    endcase
    s_next.dout = s_next.tx[flash_loader_pkg::BYTE_W-1]; // RQ14
    // only the host's configuration reset starts reloading
    if (s_reg.rcf_s[1] && !s_reg.rcf_prev) begin
      s_next.reconfig = 1'b1; // RQ9 RQ10 RQ11
    end
    if (s_next.reconfig) begin
      // release the pins so the memory can load every device
      s_next.st = flash_loader_pkg::XFER_IDLE; // RQ11
      s_next.sck = flash_loader_pkg::RST_SCK;
      s_next.sel_n = flash_loader_pkg::RST_SELECT_N;
      s_next.oe = flash_loader_pkg::RST_OE; // RQ12
      s_next.chain_n = flash_loader_pkg::RST_CHAIN_N;
    end else begin
      s_next.oe = 1'b1; // RQ2
      s_next.chain_n = 1'b0; // RQ16
    end
    // user mode drops in the same edge as reconfiguration starts
    s_next.umode = ~s_next.reconfig; // RQ8
  end

  // system clock registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.st <= flash_loader_pkg::XFER_IDLE;
      s_reg.sck <= flash_loader_pkg::RST_SCK;
      s_reg.sel_n <= flash_loader_pkg::RST_SELECT_N;
      s_reg.oe <= flash_loader_pkg::RST_OE;
      s_reg.chain_n <= flash_loader_pkg::RST_CHAIN_N;
      // user mode output straight from its own flop
      s_reg.umode <= flash_loader_pkg::RST_USER_MODE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // completion line not consulted: bridge is in user mode once loaded
  assign user_mode = s_reg.umode; // RQ8
  assign tdo = t_reg.tdo;
  assign as_abort = s_reg.abort;
  assign reconfig_start = s_reg.reconfig;
  assign chain_enable_out_n = s_reg.chain_n;
  assign serial_memory_clock = s_reg.sck;
  assign memory_select_out_n = s_reg.sel_n;
  assign serial_memory_data_out = s_reg.dout;
  assign serial_memory_oe = s_reg.oe;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // command taken from an idle engine
  sequence s_cmd_taken;
    req_edge && s_reg.st == flash_loader_pkg::XFER_IDLE && !s_reg.reconfig;
  endsequence
  // engine running with memory selected
  sequence s_selected_run;
    s_reg.st == flash_loader_pkg::XFER_LOW && !memory_select_out_n;
  endsequence

  a_cmd_starts_byte: assert property (s_cmd_taken |=> s_selected_run) // RQ3
    else $error("command did not start a byte");
  a_abort_jtag_wins: assert property ($rose(s_reg.jcfg_s[1]) |=> as_abort) // RQ1
    else $error("active serial not aborted");
  a_clock_when_sel: assert property (serial_memory_clock |-> !memory_select_out_n) // RQ4
    else $error("serial clock without select");
  a_idle_clock_low: assert property ( // RQ17
    s_reg.st == flash_loader_pkg::XFER_IDLE && s_reg.sel_n |=> !serial_memory_clock)
    else $error("serial clock active while idle");
  a_no_self_reconf: assert property ( // RQ9
    $rose(reconfig_start) |-> $past(config_reset_pulse, 3))
    else $error("reconfiguration without host pulse");
  a_release_pins: assert property ( // RQ12
    reconfig_start |=> !serial_memory_oe && memory_select_out_n && chain_enable_out_n)
    else $error("pins not released in reconfiguration");
  a_user_mode_hold: assert property (!reconfig_start |-> user_mode) // RQ8
    else $error("user mode lost without reconfiguration");
  // low for a whole divider half period before each rise
  a_half_period: assert property ( // RQ13
    $rose(serial_memory_clock) && !use_user_clock && !$past(use_user_clock, 5)
    |-> !$past(serial_memory_clock, 5))
    else $error("serial clock half period wrong");
  a_chain_enabled: assert property (!reconfig_start |=> !chain_enable_out_n
    || reconfig_start) // RQ16
    else $error("chain enable not driven low");
  a_busy_refuse: assert property (@(posedge tck) disable iff (rst)
    update_dr && busy |=> $stable(t_reg.cmd)) // RQ3
    else $error("command overwritten while busy");

  // ----------------------------------------
  // pin timing and mode checks
  // ----------------------------------------
  // returned data has synced before the first rising clock
  a_settle_first: assert property ( // RQ4
    $fell(memory_select_out_n) |-> !serial_memory_clock [*3])
    else $error("serial clock rose too soon after select");
  // pins driven from the first edge out of reset until reload
  a_pins_driven: assert property ( // RQ2
    user_mode |=> serial_memory_oe || reconfig_start)
    else $error("serial memory pins not driven");
  // user mode ends exactly when reconfiguration begins
  a_mode_drops: assert property ($rose(reconfig_start) |-> !user_mode) // RQ11
    else $error("user mode kept during reconfiguration");
endmodule // flash_loader_bridge

// [test/serial_memory_model.sv]
/*
  behavioural serial memory on the far side of the bridge, mode 0.
  assumes clock idles low and select is active low.
*/
`timescale 1ns/10ps
module serial_memory_model (
  // pins from the bridge
  input wire logic sck,
  input wire logic sel_n,
  input wire logic mosi,
  // reply to send, byte seen
  input wire logic [7:0] resp,
  output logic miso,
  output logic [7:0] rx_byte,
  output logic rx_tick
);
  logic [7:0] sh; // incoming bits
  logic [7:0] tx; // outgoing bits
  int cnt; // bits seen in this byte
  initial begin
    miso = 1'b0;
    rx_tick = 1'b0;
    cnt = 0;
  end
  // first reply bit stands before the first rise
  always @(negedge sel_n) begin
    cnt = 0;
    tx = resp;
    miso = tx[7];
  end
  // a new reply between bytes of one selection replaces the stale one
  always @(resp) if (!sel_n && cnt == 0) begin
    tx = resp;
    miso = tx[7];
  end
  // sample on rise, msb first
  always @(posedge sck) if (!sel_n) begin
    sh = {sh[6:0], mosi};
    cnt = cnt + 1;
    if (cnt == 8) begin
      rx_byte = sh;
      rx_tick = ~rx_tick;
      cnt = 0;
    end
  end
  // shift reply on fall, reload at byte start
  always @(negedge sck) if (!sel_n) begin
    tx = (cnt == 0) ? resp : {tx[6:0], 1'b0};
    miso = tx[7];
  end
  // released line shows the inverse of its last bit
  always @(posedge sel_n) miso = ~miso;
endmodule // serial_memory_model

// [test/testbench.sv]
/*
  self-checking bench for the jtag to serial memory bridge.
  assumes the bench acts as jtag host and tap, memory is a model.
*/
`timescale 1ns/10ps
module testbench;
  logic clk_sys, rst, tck, tdi, capture_dr, shift_dr, update_dr, tdo;
  logic jtag_config_active, config_reset_pulse, use_user_clock, user_clock_in;
  logic as_abort, user_mode, reconfig_start, chain_enable_out_n;
  logic serial_memory_clock, memory_select_out_n, serial_memory_data_out;
  logic serial_memory_oe, memory_data_return, rx_tick;
  logic [7:0] resp, rx_byte, b, r;
  logic [8:0] c;
  logic [7:0] q[$]; // bytes the memory should see
  int n_errors = 0;
  int n_tests = 0;
  // ----------------------------------------
  // clocks
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    tck = 1'b0;
    #7;
    forever #62.5 tck = ~tck;
  end
  initial begin
    user_clock_in = 1'b0;
    forever #25 user_clock_in = ~user_clock_in;
  end
  // ----------------------------------------
  // instances
  // ----------------------------------------
  // bench hosts one master device and one serial memory model
  flash_loader_bridge dut_u (.clk_sys(clk_sys), .rst(rst), .tck(tck), .tdi(tdi),
    .capture_dr(capture_dr), .shift_dr(shift_dr), .update_dr(update_dr), .tdo(tdo),
    .jtag_config_active(jtag_config_active), .config_reset_pulse(config_reset_pulse),
    .use_user_clock(use_user_clock), .user_clock_in(user_clock_in), .as_abort(as_abort),
    .user_mode(user_mode), .reconfig_start(reconfig_start),
    .chain_enable_out_n(chain_enable_out_n), .serial_memory_clock(serial_memory_clock),
    .memory_select_out_n(memory_select_out_n),
    .serial_memory_data_out(serial_memory_data_out), .serial_memory_oe(serial_memory_oe),
    .memory_data_return(memory_data_return));
  serial_memory_model mem_u (.sck(serial_memory_clock), .sel_n(memory_select_out_n),
    .mosi(serial_memory_data_out), .resp(resp), .miso(memory_data_return),
    .rx_byte(rx_byte), .rx_tick(rx_tick));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // compare and count
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // capture, nine shifts lsb first, optional update
  task scan(input logic [8:0] w, input logic upd, output logic [8:0] cap);
    @(negedge tck) capture_dr = 1'b1;
    @(negedge tck) capture_dr = 1'b0;
    shift_dr = 1'b1;
    for (int i = 0; i < 9; i++) begin
      if (i > 0) @(negedge tck);
      tdi = w[i];
      cap[i] = tdo;
    end
    @(negedge tck) shift_dr = 1'b0;
    update_dr = upd;
    @(negedge tck) update_dr = 1'b0;
  endtask
  // wait for busy low, bounded
  task poll(output logic [8:0] cap);
    int n;
    n = 0;
    do begin
      scan(9'h000, 1'b0, cap);
      n++;
    end while (cap[8] !== 1'b0 && n < 40);
    if (cap[8] !== 1'b0) chk(8'h01, 8'h00);
  endtask
  // one byte to memory, reply checked afterwards
  task send(input logic [7:0] d, input logic last, input logic [7:0] rsp);
    poll(c);
    resp = rsp;
    q.push_back(d);
    scan({last, d}, 1'b1, c);
    poll(c);
    chk(c[7:0], rsp);
  endtask
  task end_sim;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // watchers
  // ----------------------------------------
  // each byte at the memory against the oldest note
  always @(rx_tick) if (!rst) begin
    if (q.size() == 0) chk(8'h01, 8'h00);
    else chk(rx_byte, q.pop_front());
  end
  initial begin
    #400us;
    n_errors++;
    $display("BAD %0t timeout", $time);
    end_sim;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {rst, tdi, capture_dr, shift_dr, update_dr, jtag_config_active} = 6'h20;
    {config_reset_pulse, use_user_clock, resp} = 10'h000;
    void'($urandom(6188));
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    @(negedge clk_sys);
    chk({1'b0, user_mode, chain_enable_out_n, memory_select_out_n, serial_memory_clock,
      serial_memory_oe, reconfig_start, as_abort}, 8'h54);
    $display("test reset done");
    // bytes, system then user clock; select held until last
    for (int k = 0; k < 2; k++) begin
      @(negedge clk_sys) use_user_clock = k[0];
      for (int j = 0; j < 3; j++) begin
        b = 8'($urandom);
        r = 8'($urandom);
        send(j == 0 ? 8'hff : b, j == 2, j == 1 ? 8'h00 : r);
      end
      chk({6'h00, memory_select_out_n, serial_memory_clock}, 8'h02);
    end
    // update while busy is refused, so the memory sees one byte only
    resp = 8'h5a;
    q.push_back(8'h3c);
    scan(9'h13c, 1'b1, c);
    @(negedge tck) update_dr = 1'b1;
    @(negedge tck) update_dr = 1'b0;
    poll(c);
    chk(c[7:0], 8'h5a);
    $display("test transfer done");
    // jtag wins over active serial
    @(negedge clk_sys) jtag_config_active = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk({7'h00, as_abort}, 8'h01);
    jtag_config_active = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk({7'h00, as_abort}, 8'h00);
    $display("test abort done");
    // no reconfiguration by itself, then host pulse
    repeat (200) @(negedge clk_sys);
    chk({7'h00, reconfig_start}, 8'h00);
    config_reset_pulse = 1'b1;
    repeat (3) @(negedge clk_sys);
    config_reset_pulse = 1'b0;
    repeat (6) @(negedge clk_sys);
    chk({3'h0, reconfig_start, serial_memory_oe, memory_select_out_n, chain_enable_out_n,
      user_mode}, 8'h16);
    scan(9'h1a5, 1'b1, c);
    #3us;
    chk({7'h00, memory_select_out_n}, 8'h01);
    $display("test reconfig done");
    end_sim;
  end
endmodule // testbench
